// file: design/channel_monitor_config_regs.sv
`timescale 1ns/1ps
// Functional notes
// - At 1x scaling a threshold code means 0.2V plus 5mV per step, up to 1.475V.
// - At 4x scaling a threshold code means 0.8V plus 20mV per step.
// - Each channel holds four 8-bit thresholds; the overvoltage ones reset to all ones.
// - Undervoltage thresholds reset to zero.
// - A fast fault is reported only after the comparator held for the full debounce time.
// - Debounce bits 7:4 time the overvoltage path and bits 3:0 the undervoltage path.
// - Debounce code 0 is 0.1us, doubling per code to 51.2us at 9; codes 10-15 are 102.4us.
// - Map bits 4:3 route fast faults to reset: 00 none, 01 under, 10 over, 11 both.
// - The cutoff-and-mapping register resets to 0x14: over mapped, 1kHz cutoff.
// - Cutoff codes 2..6 give 250Hz..4kHz; codes 0, 1 and 7 are invalid.
// - Writing the cutoff code retunes the low-frequency path filter.
// - Channel 2 registers sit at 0x30 through 0x35 in the listed order.
module channel_monitor_config_regs #(
	parameter int unsigned DEBOUNCE_MAX_CYCLES = supervisor_cfg_pkg::DEBOUNCE_MAX_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire supervisor_cfg_pkg::reg_req_t i_reg_req,
	output supervisor_cfg_pkg::reg_rsp_t o_reg_rsp,
	input wire logic i_range_scale_select,
	input wire logic i_ch1_fast_undervoltage_fault,
	input wire logic i_ch1_fast_overvoltage_fault,
	input wire logic i_ch2_fast_under_cmp,
	input wire logic i_ch2_fast_over_cmp,
	output supervisor_cfg_pkg::ch_thresholds_t o_ch2_thresholds,
	output logic [2:0] o_ch1_slow_cutoff,
	output logic [2:0] o_ch2_slow_cutoff,
	output logic o_ch2_fast_undervoltage_fault,
	output logic o_ch2_fast_overvoltage_fault,
	output logic o_reset_output_n
);
	logic [7:0] ch1_slow_cutoff_reset_map;
	logic [7:0] ch2_fast_under_threshold;
	logic [7:0] ch2_fast_over_threshold;
	logic [7:0] ch2_slow_under_threshold;
	logic [7:0] ch2_slow_over_threshold;
	logic [7:0] ch2_fast_debounce;
	logic [7:0] ch2_slow_cutoff_reset_map;

	// address decode
	wire wr = i_reg_req.wr;
	wire hit_ch1_map = i_reg_req.addr == supervisor_cfg_pkg::ADDR_CH1_SLOW_CUTOFF_RESET_MAP;
	wire hit_fuv = i_reg_req.addr == supervisor_cfg_pkg::ADDR_CH2_FAST_UNDER_THRESHOLD;
	wire hit_fov = i_reg_req.addr == supervisor_cfg_pkg::ADDR_CH2_FAST_OVER_THRESHOLD;
	wire hit_suv = i_reg_req.addr == supervisor_cfg_pkg::ADDR_CH2_SLOW_UNDER_THRESHOLD;
	wire hit_sov = i_reg_req.addr == supervisor_cfg_pkg::ADDR_CH2_SLOW_OVER_THRESHOLD;
	wire hit_deb = i_reg_req.addr == supervisor_cfg_pkg::ADDR_CH2_FAST_DEBOUNCE;
	wire hit_ch2_map = i_reg_req.addr == supervisor_cfg_pkg::ADDR_CH2_SLOW_CUTOFF_RESET_MAP;

	// writable bits only; reserved bits stay zero
	wire [7:0] map_wdata = i_reg_req.wdata & supervisor_cfg_pkg::CUTOFF_RESET_MAP_WRITABLE;

	wire [7:0] next_rdata;
	assign next_rdata = hit_ch1_map ? ch1_slow_cutoff_reset_map :
		hit_fuv ? ch2_fast_under_threshold :
		hit_fov ? ch2_fast_over_threshold :
		hit_suv ? ch2_slow_under_threshold :
		hit_sov ? ch2_slow_over_threshold :
		hit_deb ? ch2_fast_debounce :
		hit_ch2_map ? ch2_slow_cutoff_reset_map : 8'h00;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ch1_slow_cutoff_reset_map <= supervisor_cfg_pkg::CUTOFF_RESET_MAP_RESET;
			ch2_fast_under_threshold <= supervisor_cfg_pkg::UNDER_THRESHOLD_RESET;
			ch2_fast_over_threshold <= supervisor_cfg_pkg::OVER_THRESHOLD_RESET;
			ch2_slow_under_threshold <= supervisor_cfg_pkg::UNDER_THRESHOLD_RESET;
			ch2_slow_over_threshold <= supervisor_cfg_pkg::OVER_THRESHOLD_RESET;
			ch2_fast_debounce <= supervisor_cfg_pkg::FAST_DEBOUNCE_RESET;
			ch2_slow_cutoff_reset_map <= supervisor_cfg_pkg::CUTOFF_RESET_MAP_RESET;
		end else if (wr) begin
			if (hit_ch1_map) begin
				ch1_slow_cutoff_reset_map <= map_wdata;
			end
			if (hit_fuv) begin
				ch2_fast_under_threshold <= i_reg_req.wdata;
			end
			if (hit_fov) begin
				ch2_fast_over_threshold <= i_reg_req.wdata;
			end
			if (hit_suv) begin
				ch2_slow_under_threshold <= i_reg_req.wdata;
			end
			if (hit_sov) begin
				ch2_slow_over_threshold <= i_reg_req.wdata;
			end
			if (hit_deb) begin
				ch2_fast_debounce <= i_reg_req.wdata;
			end
			if (hit_ch2_map) begin
				ch2_slow_cutoff_reset_map <= map_wdata;
			end
		end
	end

	// every read or write is acknowledged one cycle later; unmapped reads return zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rsp <= '0;
		end else begin
			o_reg_rsp.ack <= i_reg_req.wr | i_reg_req.rd;
			if (i_reg_req.rd) begin
				o_reg_rsp.rdata <= next_rdata;
			end
		end
	end

	// threshold code to millivolts
	function automatic logic [12:0] code_to_mv(input logic [7:0] code, input logic scale4);
		logic [12:0] wide;
		wide = {5'h00, code};
		if (scale4) begin
			code_to_mv = supervisor_cfg_pkg::SCALE4_BASE_MV
				+ 13'(wide * supervisor_cfg_pkg::SCALE4_STEP_MV);
		end else begin
			code_to_mv = supervisor_cfg_pkg::SCALE1_BASE_MV
				+ 13'(wide * supervisor_cfg_pkg::SCALE1_STEP_MV);
		end
	endfunction

	supervisor_cfg_pkg::ch_thresholds_t next_thresholds;
	assign next_thresholds.fast_under_mv = code_to_mv(ch2_fast_under_threshold,
		i_range_scale_select);
	assign next_thresholds.fast_over_mv = code_to_mv(ch2_fast_over_threshold,
		i_range_scale_select);
	assign next_thresholds.slow_under_mv = code_to_mv(ch2_slow_under_threshold,
		i_range_scale_select);
	assign next_thresholds.slow_over_mv = code_to_mv(ch2_slow_over_threshold,
		i_range_scale_select);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ch2_thresholds.fast_under_mv <= supervisor_cfg_pkg::SCALE1_BASE_MV;
			o_ch2_thresholds.fast_over_mv <= supervisor_cfg_pkg::SCALE1_TOP_MV;
			o_ch2_thresholds.slow_under_mv <= supervisor_cfg_pkg::SCALE1_BASE_MV;
			o_ch2_thresholds.slow_over_mv <= supervisor_cfg_pkg::SCALE1_TOP_MV;
		end else begin
			o_ch2_thresholds <= next_thresholds;
		end
	end

	// cutoff selection: only valid codes reach the filter
	function automatic logic cutoff_valid(input logic [2:0] code);
		cutoff_valid = (code >= supervisor_cfg_pkg::CUTOFF_250HZ) &&
			(code <= supervisor_cfg_pkg::CUTOFF_4KHZ);
	endfunction

	wire [2:0] ch1_cutoff_field = ch1_slow_cutoff_reset_map[supervisor_cfg_pkg::CUTOFF_MSB:
		supervisor_cfg_pkg::CUTOFF_LSB];
	wire [2:0] ch2_cutoff_field = ch2_slow_cutoff_reset_map[supervisor_cfg_pkg::CUTOFF_MSB:
		supervisor_cfg_pkg::CUTOFF_LSB];

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ch1_slow_cutoff <= supervisor_cfg_pkg::CUTOFF_1KHZ;
			o_ch2_slow_cutoff <= supervisor_cfg_pkg::CUTOFF_1KHZ;
		end else begin
			if (cutoff_valid(ch1_cutoff_field)) begin
				o_ch1_slow_cutoff <= ch1_cutoff_field;
			end
			if (cutoff_valid(ch2_cutoff_field)) begin
				o_ch2_slow_cutoff <= ch2_cutoff_field;
			end
		end
	end

	// fast comparator debounce, index 0 under and 1 over
	wire [1:0] cmp_async = {i_ch2_fast_over_cmp, i_ch2_fast_under_cmp};
	wire [3:0] settle_code [2];
	wire [1:0] fast_fault;
	assign settle_code[0] = ch2_fast_debounce[supervisor_cfg_pkg::UNDER_SETTLE_MSB:
		supervisor_cfg_pkg::UNDER_SETTLE_LSB];
	assign settle_code[1] = ch2_fast_debounce[supervisor_cfg_pkg::OVER_SETTLE_MSB:
		supervisor_cfg_pkg::OVER_SETTLE_LSB];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_debounce
			fast_fault_debounce #(
				.MAX_CYCLES(DEBOUNCE_MAX_CYCLES)
			) u_debounce (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_level_async(cmp_async[g]),
				.i_code(settle_code[g]),
				.o_level(fast_fault[g])
			);
		end
	endgenerate

	assign o_ch2_fast_undervoltage_fault = fast_fault[0];
	assign o_ch2_fast_overvoltage_fault = fast_fault[1];

	// reset output mapping
	wire [1:0] ch1_map = ch1_slow_cutoff_reset_map[supervisor_cfg_pkg::RESET_MAP_MSB:
		supervisor_cfg_pkg::RESET_MAP_LSB];
	wire [1:0] ch2_map = ch2_slow_cutoff_reset_map[supervisor_cfg_pkg::RESET_MAP_MSB:
		supervisor_cfg_pkg::RESET_MAP_LSB];
	wire ch1_routed = (ch1_map[supervisor_cfg_pkg::RESET_MAP_UNDER_BIT]
		& i_ch1_fast_undervoltage_fault) | (ch1_map[supervisor_cfg_pkg::RESET_MAP_OVER_BIT]
		& i_ch1_fast_overvoltage_fault);
	wire ch2_routed = (ch2_map[supervisor_cfg_pkg::RESET_MAP_UNDER_BIT] & fast_fault[0])
		| (ch2_map[supervisor_cfg_pkg::RESET_MAP_OVER_BIT] & fast_fault[1]);
	wire next_reset_output_n = ~(ch1_routed | ch2_routed);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reset_output_n <= 1'b0;
		end else begin
			o_reset_output_n <= next_reset_output_n;
		end
	end
endmodule // channel_monitor_config_regs

// file: inc/supervisor_cfg_pkg.sv
package supervisor_cfg_pkg;

	// register offsets
	localparam logic [7:0] ADDR_CH1_SLOW_CUTOFF_RESET_MAP = 8'h25;
	localparam logic [7:0] ADDR_CH2_FAST_UNDER_THRESHOLD = 8'h30;
	localparam logic [7:0] ADDR_CH2_FAST_OVER_THRESHOLD = 8'h31;
	localparam logic [7:0] ADDR_CH2_SLOW_UNDER_THRESHOLD = 8'h32;
	localparam logic [7:0] ADDR_CH2_SLOW_OVER_THRESHOLD = 8'h33;
	localparam logic [7:0] ADDR_CH2_FAST_DEBOUNCE = 8'h34;
	localparam logic [7:0] ADDR_CH2_SLOW_CUTOFF_RESET_MAP = 8'h35;

	// reset values
	localparam logic [7:0] UNDER_THRESHOLD_RESET = 8'h00;
	localparam logic [7:0] OVER_THRESHOLD_RESET = 8'hff;
	localparam logic [7:0] FAST_DEBOUNCE_RESET = 8'h00;
	localparam logic [7:0] CUTOFF_RESET_MAP_RESET = 8'h14;

	// field positions
	localparam int OVER_SETTLE_MSB = 7;
	localparam int OVER_SETTLE_LSB = 4;
	localparam int UNDER_SETTLE_MSB = 3;
	localparam int UNDER_SETTLE_LSB = 0;
	localparam int RESET_MAP_MSB = 4;
	localparam int RESET_MAP_LSB = 3;
	localparam int RESET_MAP_UNDER_BIT = 0;
	localparam int RESET_MAP_OVER_BIT = 1;
	localparam int CUTOFF_MSB = 2;
	localparam int CUTOFF_LSB = 0;
	localparam logic [7:0] CUTOFF_RESET_MAP_WRITABLE = 8'h1f;

	// low-pass cutoff codes
	localparam logic [2:0] CUTOFF_250HZ = 3'h2;
	localparam logic [2:0] CUTOFF_500HZ = 3'h3;
	localparam logic [2:0] CUTOFF_1KHZ = 3'h4;
	localparam logic [2:0] CUTOFF_2KHZ = 3'h5;
	localparam logic [2:0] CUTOFF_4KHZ = 3'h6;

	// threshold scaling in millivolts
	localparam logic [12:0] SCALE1_BASE_MV = 13'h00c8;
	localparam logic [12:0] SCALE1_STEP_MV = 13'h0005;
	localparam logic [12:0] SCALE1_TOP_MV = 13'h05c3;
	localparam logic [12:0] SCALE4_BASE_MV = 13'h0320;
	localparam logic [12:0] SCALE4_STEP_MV = 13'h0014;

	// debounce timing
	localparam int CLK_MHZ = 125;
	localparam int DEBOUNCE_MIN_NS = 100;
	localparam int DEBOUNCE_MAX_NS = 102400;
	localparam int DEBOUNCE_MAX_CODE = 10;
	localparam int DEBOUNCE_MAX_CYCLES = (DEBOUNCE_MAX_NS * CLK_MHZ + 999) / 1000;
	localparam int DEBOUNCE_MIN_CYCLES = (DEBOUNCE_MIN_NS * CLK_MHZ + 999) / 1000;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic ack;
	} reg_rsp_t;

	typedef struct packed {
		logic [12:0] fast_under_mv;
		logic [12:0] fast_over_mv;
		logic [12:0] slow_under_mv;
		logic [12:0] slow_over_mv;
	} ch_thresholds_t;

endpackage

// file: design/fast_fault_debounce.sv
`timescale 1ns/1ps
module fast_fault_debounce #(
	parameter int unsigned MAX_CYCLES = 12800
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_level_async,
	input wire logic [3:0] i_code,
	output logic o_level
);
	logic sync1;
	logic sync2;
	logic [15:0] count;
	wire [15:0] limit;
	wire count_done;

	// cycles = ceil(max / 2^(10-code)); codes above 10 saturate at the maximum
	function automatic logic [15:0] code_cycles(input logic [3:0] code);
		int unsigned shift;
		shift = (int'(code) >= supervisor_cfg_pkg::DEBOUNCE_MAX_CODE) ? 0 :
			unsigned'(supervisor_cfg_pkg::DEBOUNCE_MAX_CODE - int'(code));
		code_cycles = 16'((MAX_CYCLES + (32'h1 << shift) - 1) >> shift);
	endfunction

	assign limit = code_cycles(i_code);
	assign count_done = (count + 16'h0001) >= limit;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
		end else begin
			sync1 <= i_level_async;
			sync2 <= sync1;
		end
	end

	// the new level must hold for the whole interval; any return restarts it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= 16'h0000;
			o_level <= 1'b0;
		end else if (sync2 == o_level) begin
			count <= 16'h0000;
		end else if (count_done) begin
			count <= 16'h0000;
			o_level <= sync2;
		end else begin
			count <= count + 16'h0001;
		end
	end
endmodule // fast_fault_debounce

// file: testbench/channel_monitor_config_regs_monitor.sv
`timescale 1ns/1ps
module channel_monitor_config_regs_monitor (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire supervisor_cfg_pkg::reg_req_t i_reg_req,
	input wire supervisor_cfg_pkg::reg_rsp_t o_reg_rsp,
	input wire logic i_range_scale_select,
	input wire logic i_ch2_fast_over_cmp,
	input wire supervisor_cfg_pkg::ch_thresholds_t o_ch2_thresholds,
	input wire logic [2:0] o_ch2_slow_cutoff,
	input wire logic o_ch2_fast_overvoltage_fault,
	input wire logic o_reset_output_n
);
	logic [7:0] under_code;
	logic over_map;
	wire logic acc = i_reg_req.wr | i_reg_req.rd;
	wire logic w35 = i_reg_req.wr && i_reg_req.addr == 8'h35;
	wire logic mapped = i_reg_req.addr inside {8'h25, [8'h30:8'h35]};
	wire logic [12:0] mv = i_range_scale_select ? 13'h320 + 13'h014 * {5'h00, under_code}
		: 13'h0c8 + 13'h005 * {5'h00, under_code};
	// shadows of the fast under threshold and the over mapping bit
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			under_code <= 8'h00;
			over_map <= 1'b1;
		end else if (i_reg_req.wr && i_reg_req.addr == 8'h30) begin
			under_code <= i_reg_req.wdata;
		end else if (w35) begin
			over_map <= i_reg_req.wdata[4];
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_ack_follows: assert property (acc |=> o_reg_rsp.ack) else $error("no ack");
	chk_ack_idle: assert property (!acc |=> !o_reg_rsp.ack) else $error("stray ack");
	chk_unmapped_zero: assert property (i_reg_req.rd && !mapped
		|=> o_reg_rsp.rdata == 8'h00) else $error("unmapped read not zero");
	chk_reserved_zero: assert property (i_reg_req.rd && mapped
		&& i_reg_req.addr[3:0] == 4'h5 |=> o_reg_rsp.rdata[7:5] == 3'h0)
		else $error("reserved bits set");
	chk_cutoff_range: assert property (o_ch2_slow_cutoff inside {[3'h2:3'h6]})
		else $error("invalid cutoff applied");
	chk_cutoff_apply: assert property (w35
		&& i_reg_req.wdata[2:0] inside {[3'h2:3'h6]}
		|=> ##1 o_ch2_slow_cutoff == $past(i_reg_req.wdata[2:0], 2))
		else $error("cutoff not applied");
	chk_thresh_scale: assert property (
		o_ch2_thresholds.fast_under_mv == $past(mv)) else $error("threshold scaling wrong");
	chk_over_reset: assert property (o_ch2_fast_overvoltage_fault
		&& over_map |=> !o_reset_output_n) else $error("mapped over fault not on reset");
	chk_fault_settle: assert property ($rose(o_ch2_fast_overvoltage_fault)
		|-> $past(i_ch2_fast_over_cmp, 3)) else $error("fault without held input");
endmodule // channel_monitor_config_regs_monitor
bind channel_monitor_config_regs channel_monitor_config_regs_monitor u_mon (.i_clk(i_clk),
	.i_rst(i_rst), .i_reg_req(i_reg_req), .o_reg_rsp(o_reg_rsp),
	.i_range_scale_select(i_range_scale_select), .i_ch2_fast_over_cmp(i_ch2_fast_over_cmp),
	.o_ch2_thresholds(o_ch2_thresholds), .o_ch2_slow_cutoff(o_ch2_slow_cutoff),
	.o_ch2_fast_overvoltage_fault(o_ch2_fast_overvoltage_fault),
	.o_reset_output_n(o_reset_output_n));

// file: testbench/supervisor_host.sv
`timescale 1ns/1ps
module supervisor_host (
	input wire logic i_clk,
	input wire supervisor_cfg_pkg::reg_rsp_t i_rsp,
	output supervisor_cfg_pkg::reg_req_t o_req
);
	initial o_req = '0;
	// one-cycle strobe; address and data stay until the ack is seen
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		int n;
		o_req = {a, d, w, !w};
		@(negedge i_clk);
		o_req.wr = 1'b0;
		o_req.rd = 1'b0;
		n = 0;
		while (i_rsp.ack !== 1'b1 && n < 4) begin
			@(negedge i_clk);
			n++;
		end
		ok = (i_rsp.ack === 1'b1);
		q = i_rsp.rdata;
		// let one edge pass so the next strobe never shares a time step with this clear
		@(negedge i_clk);
	endtask
endmodule // supervisor_host

// file: testbench/channel_monitor_config_regs_tb.sv
`timescale 1ns/1ps
module channel_monitor_config_regs_tb;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} row_t;
	logic i_clk = 1'b0;
	logic rst = 1'b1;
	logic scale = 1'b0;
	logic c1u = 1'b0;
	logic c1o = 1'b0;
	logic c2u = 1'b0;
	logic c2o = 1'b0;
	supervisor_cfg_pkg::reg_req_t req;
	supervisor_cfg_pkg::reg_rsp_t rsp;
	supervisor_cfg_pkg::ch_thresholds_t thr;
	logic [2:0] cut1;
	logic [2:0] cut2;
	logic uf;
	logic of;
	logic rst_n;
	logic [7:0] q;
	logic ok;
	int err_total = 0;
	int num_checks = 0;
	// debounce 0x32 keeps both codes inside the supported span
	row_t rows [24] = '{25'h0_30_00_00, 25'h0_31_00_ff, 25'h0_32_00_00, 25'h0_33_00_ff,
		25'h0_34_00_00, 25'h0_35_00_14, 25'h0_25_00_14, 25'h1_30_a5_00, 25'h1_31_5a_00,
		25'h1_34_32_00, 25'h1_35_ff_00, 25'h0_30_00_a5, 25'h0_31_00_5a, 25'h0_34_00_32,
		25'h0_35_00_1f, 25'h1_36_77_00, 25'h0_36_00_00, 25'h0_2f_00_00, 25'h1_32_3c_00,
		25'h1_33_c3_00, 25'h1_25_f5_00, 25'h0_32_00_3c, 25'h0_33_00_c3, 25'h0_25_00_15};
	channel_monitor_config_regs #(.DEBOUNCE_MAX_CYCLES(1024)) dut (.i_clk(i_clk), .i_rst(rst),
		.i_reg_req(req), .o_reg_rsp(rsp), .i_range_scale_select(scale),
		.i_ch1_fast_undervoltage_fault(c1u), .i_ch1_fast_overvoltage_fault(c1o),
		.i_ch2_fast_under_cmp(c2u), .i_ch2_fast_over_cmp(c2o), .o_ch2_thresholds(thr),
		.o_ch1_slow_cutoff(cut1), .o_ch2_slow_cutoff(cut2), .o_ch2_fast_undervoltage_fault(uf),
		.o_ch2_fast_overvoltage_fault(of), .o_reset_output_n(rst_n));
	supervisor_host u_host (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
	initial begin
		forever #4 i_clk = ~i_clk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input logic [51:0] got, input logic [51:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		u_host.access(w, a, d, q, ok);
		if (!ok) begin
			err_total++;
			summarize();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	initial begin
		tick(8);
		rst = 1'b0;
		tick(1);
		cmp(thr, {13'h0c8, 13'h5c3, 13'h0c8, 13'h5c3});
		foreach (rows[k]) begin
			acc(rows[k].w, rows[k].a, rows[k].d);
			if (!rows[k].w) cmp(q, rows[k].e);
		end
		cmp(thr, {13'h401, 13'h28a, 13'h1f4, 13'h497});
		cmp({cut1, cut2}, {3'h5, 3'h4});
		scale = 1'b1;
		tick(2);
		cmp(thr.fast_under_mv, 13'h1004);
		scale = 1'b0;
		// codes 7 and 0 are refused and leave 4kHz applied
		for (int c = 2; c < 9; c++) begin
			acc(1'b1, 8'h35, {5'h02, c[2:0]});
			tick(1);
			cmp(cut2, (c < 7) ? c[2:0] : 3'h6);
		end
		c2o = 1'b1;
		tick(3);
		c2o = 1'b0;
		tick(12);
		cmp(of, 1'b0);
		c2u = 1'b1;
		c2o = 1'b1;
		tick(8);
		cmp({uf, of, rst_n}, 3'b101);
		tick(5);
		cmp({of, rst_n}, 2'b10);
		acc(1'b1, 8'h35, 8'h0c);
		tick(1);
		cmp(rst_n, 1'b0);
		acc(1'b1, 8'h35, 8'h04);
		tick(1);
		cmp(rst_n, 1'b1);
		c1u = 1'b1;
		tick(2);
		cmp(rst_n, 1'b1);
		c1o = 1'b1;
		tick(2);
		cmp(rst_n, 1'b0);
		// over code 15 saturates at the full interval, release is filtered too
		acc(1'b1, 8'h34, 8'hf2);
		c2o = 1'b0;
		tick(1020);
		cmp(of, 1'b1);
		tick(10);
		cmp(of, 1'b0);
		{c1u, c1o, c2u, c2o} = 4'h0;
		rst = 1'b1;
		tick(1);
		cmp({rst_n, cut2}, {1'b0, 3'h4});
		rst = 1'b0;
		acc(1'b0, 8'h35, 8'h00);
		cmp(q, 8'h14);
		summarize();
	end
endmodule // channel_monitor_config_regs_tb
